// file: verilog/dupc_map.svh
// Constants and notes on behaviour for the dual UART pin, mode and reset control
// Notes on behaviour
// - Line transmit outputs sit low during reset or when idle.
// - Channel B receive comes from line pin when select low, logic pin when high.
// - Channel B transmit stream also appears on a logic-level output.
// - Power-save while asleep isolates host bus from the core.
// - Autosleep high stops charge pump only in partial sleep, oscillator stopped.
// - Bus-style strap high selects strobe mode, low selects direction mode.
// - Reset polarity is high in strobe mode, low in direction mode.
// - Reset held for at least one 100 ns cycle is seen; a 40 ns pulse may be missed.
// - During reset the internal transmit is high and receive is ignored.
// - Oscillator input is the timebase; a buffered copy is driven out.
// - In direction mode the second select pin picks channel A or B.
`ifndef DUPC_MAP_SVH
`define DUPC_MAP_SVH
`define DUPC_CLK_PERIOD_NS 100
`define DUPC_RST_MIN_NS 40
`define DUPC_RST_MIN_CYC ((`DUPC_RST_MIN_NS + `DUPC_CLK_PERIOD_NS - 1) / `DUPC_CLK_PERIOD_NS)
`define DUPC_RST_SYNC_STAGES 2
`define DUPC_TX_IDLE 1'b1
`define DUPC_CHAN_A 1'b0
`define DUPC_CHAN_B 1'b1
`endif

// file: verilog/dupc_pkg.sv
// Types shared by the pin, mode and reset control
package dupc_pkg;
    typedef enum logic {DUPC_BUS_DIR, DUPC_BUS_STROBE} dupc_bus_mode_t;
endpackage

// file: verilog/dupc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dupc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// file: verilog/dupc_top.sv
// Pin-level mode, channel select, power and reset control of a two-channel UART
`timescale 1ns/1ps
`include "dupc_map.svh"
module dupc_top (
    // Clock and power-on reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Straps and ancillary pins
    input wire logic bus_mode_strap_i,
    input wire logic reset_pin_i,
    input wire logic bus_isolate_in_i,
    input wire logic charge_pump_autosleep_i,
    input wire logic chan_b_rx_source_sel_i,
    input wire logic chip_sel_chan_b_i,
    input wire logic osc_in_i,
    // Core sleep state
    input wire logic core_asleep_i,
    input wire logic osc_stopped_i,
    // Core serial streams (inverted line polarity: idle high)
    input wire logic core_tx_a_i,
    input wire logic core_tx_b_i,
    input wire logic core_tx_active_a_i,
    input wire logic core_tx_active_b_i,
    // Serial pins
    input wire logic line_rx_chan_a_i,
    input wire logic line_rx_chan_b_i,
    input wire logic logic_rx_chan_b_i,
    output logic line_tx_chan_a_o,
    output logic line_tx_chan_b_o,
    output logic logic_tx_chan_b_o,
    // To the core
    output logic core_rx_a_o,
    output logic core_rx_b_o,
    output logic core_rst_o,
    output dupc_pkg::dupc_bus_mode_t bus_mode_o,
    output logic bus_isolate_o,
    output logic chan_select_addr_o,
    output logic charge_pump_off_o,
    output logic osc_buffered_out_o
);
    import dupc_pkg::*;

    // Slots of the pins in the synchroniser word
    localparam int NSYNC = 9;
    localparam int PIN_STRAP = 8;
    localparam int PIN_RST = 7;
    localparam int PIN_ISO = 6;
    localparam int PIN_ACP = 5;
    localparam int PIN_RXSEL = 4;
    localparam int PIN_CSB = 3;
    localparam int PIN_RXA = 2;
    localparam int PIN_RXB_LINE = 1;
    localparam int PIN_RXB_LOGIC = 0;

    wire [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] pins_s;
    logic strap_s;
    logic rst_pin_s;
    logic iso_s;
    logic acp_s;
    logic rxsel_s;
    logic csb_s;
    logic rxa_s;
    logic rxb_line_s;
    logic rxb_logic_s;

    // Every pin from outside the clock domain except the oscillator input goes through the two flops
    assign pins_raw[PIN_STRAP] = bus_mode_strap_i;
    assign pins_raw[PIN_RST] = reset_pin_i;
    assign pins_raw[PIN_ISO] = bus_isolate_in_i;
    assign pins_raw[PIN_ACP] = charge_pump_autosleep_i;
    assign pins_raw[PIN_RXSEL] = chan_b_rx_source_sel_i;
    assign pins_raw[PIN_CSB] = chip_sel_chan_b_i;
    assign pins_raw[PIN_RXA] = line_rx_chan_a_i;
    assign pins_raw[PIN_RXB_LINE] = line_rx_chan_b_i;
    assign pins_raw[PIN_RXB_LOGIC] = logic_rx_chan_b_i;

    dupc_sync #(.WIDTH(NSYNC)) u_sync (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(pins_raw),
        .sync_o(pins_s)
    );

    // Named views of the synchronised pins
    assign strap_s = pins_s[PIN_STRAP];
    assign rst_pin_s = pins_s[PIN_RST];
    assign iso_s = pins_s[PIN_ISO];
    assign acp_s = pins_s[PIN_ACP];
    assign rxsel_s = pins_s[PIN_RXSEL];
    assign csb_s = pins_s[PIN_CSB];
    assign rxa_s = pins_s[PIN_RXA];
    assign rxb_line_s = pins_s[PIN_RXB_LINE];
    assign rxb_logic_s = pins_s[PIN_RXB_LOGIC];

    // Strap is caught only once the synchroniser holds the real pin level;
    // taking it on the first edge would read the flops' reset value instead
    logic [`DUPC_RST_SYNC_STAGES-1:0] sync_fill;
    wire strap_valid;
    logic strap_seen;
    dupc_bus_mode_t bus_mode;
    // Fills with ones as the synchroniser fills with pin samples
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_fill <= '0;
        end else begin
            sync_fill <= {sync_fill[`DUPC_RST_SYNC_STAGES-2:0], 1'b1};
        end
    end
    assign strap_valid = sync_fill[`DUPC_RST_SYNC_STAGES-1];

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strap_seen <= 1'b0;
            bus_mode <= DUPC_BUS_DIR;
        end else if (strap_valid && !strap_seen) begin
            strap_seen <= 1'b1;
            bus_mode <= strap_s ? DUPC_BUS_STROBE : DUPC_BUS_DIR;
        end
    end
    assign bus_mode_o = bus_mode;

    // Active level of the reset pin depends on the bus style; until the strap
    // is known the block stays in reset whatever the pin shows
    wire rst_pin_active;
    wire rst_req;
    assign rst_pin_active = (bus_mode == DUPC_BUS_STROBE) ? rst_pin_s : !rst_pin_s;
    assign rst_req = !strap_seen || rst_pin_active;

    // Assert at once, release through two extra flops so all leave together.
    // A 40 ns pulse is shorter than one 100 ns cycle; pulses below a cycle may be missed.
    logic [`DUPC_RST_SYNC_STAGES-1:0] rst_pipe;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_pipe <= '1;
        end else begin
            rst_pipe <= {rst_pipe[`DUPC_RST_SYNC_STAGES-2:0], rst_req};
        end
    end
    wire in_reset;
    assign in_reset = rst_req || (|rst_pipe);

    // Per-channel transmit path, index 0 is channel A and 1 is channel B
    localparam int NCHAN = 2;
    wire [NCHAN-1:0] core_tx_v;
    wire [NCHAN-1:0] core_act_v;
    wire [NCHAN-1:0] tx_int_v;
    wire [NCHAN-1:0] next_line_tx;
    assign core_tx_v = {core_tx_b_i, core_tx_a_i};
    assign core_act_v = {core_tx_active_b_i, core_tx_active_a_i};
    for (genvar ch = 0; ch < NCHAN; ch++) begin : g_tx
        assign tx_int_v[ch] = in_reset ? `DUPC_TX_IDLE : core_tx_v[ch];
        // Line drivers invert: internal high mark becomes low line level
        assign next_line_tx[ch] = !in_reset && core_act_v[ch] && !tx_int_v[ch];
    end

    // Channel B receive source; the line pin is inverted, the logic pin is not
    wire rxb_pick;
    wire next_rx_a;
    wire next_rx_b;
    assign rxb_pick = rxsel_s ? rxb_logic_s : !rxb_line_s;
    assign next_rx_a = in_reset ? `DUPC_TX_IDLE : !rxa_s;
    assign next_rx_b = in_reset ? `DUPC_TX_IDLE : rxb_pick;

    // Receive outputs rest at mark in reset, so the core sees no false start bit
    logic [NCHAN-1:0] line_tx_q;
    logic ltx_b_q;
    logic rx_a_q;
    logic rx_b_q;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            line_tx_q <= '0;
            ltx_b_q <= `DUPC_TX_IDLE;
            rx_a_q <= `DUPC_TX_IDLE;
            rx_b_q <= `DUPC_TX_IDLE;
        end else begin
            line_tx_q <= next_line_tx;
            // Logic-level copy of channel B for an outside transceiver
            ltx_b_q <= tx_int_v[1];
            rx_a_q <= next_rx_a;
            rx_b_q <= next_rx_b;
        end
    end
    assign line_tx_chan_a_o = line_tx_q[0];
    assign line_tx_chan_b_o = line_tx_q[1];
    assign logic_tx_chan_b_o = ltx_b_q;
    assign core_rx_a_o = rx_a_q;
    assign core_rx_b_o = rx_b_q;
    assign core_rst_o = in_reset;

    // Power controls
    wire next_iso;
    wire next_cp_off;
    wire next_chsel;
    // Isolation only while the core sleeps, so a busy host is never cut off
    assign next_iso = iso_s && core_asleep_i;
    // Oscillator stopped means partial sleep already, so the pump may go off
    assign next_cp_off = acp_s && osc_stopped_i;
    // Strobe style has a real second chip select, so no address bit there
    assign next_chsel = (bus_mode == DUPC_BUS_DIR) ? csb_s : `DUPC_CHAN_A;

    logic iso_q;
    logic cp_off_q;
    logic chsel_q;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            iso_q <= 1'b0;
            cp_off_q <= 1'b0;
            chsel_q <= `DUPC_CHAN_A;
        end else begin
            iso_q <= next_iso;
            cp_off_q <= next_cp_off;
            chsel_q <= next_chsel;
        end
    end
    assign bus_isolate_o = iso_q;
    assign charge_pump_off_o = cp_off_q;
    assign chan_select_addr_o = chsel_q;

    // Clock passes straight through; a flop would halve or delay it
    assign osc_buffered_out_o = osc_in_i;
endmodule

// file: test/dupc_chk_checker.sv
// Port assertions for the pin, mode and reset control
`timescale 1ns/1ps
module dupc_chk (
    // Watched ports
    input wire logic core_clk_i, arst_n_i, bus_mode_strap_i, reset_pin_i, bus_isolate_in_i,
    input wire logic charge_pump_autosleep_i, chan_b_rx_source_sel_i, chip_sel_chan_b_i,
    input wire logic osc_in_i, core_asleep_i, osc_stopped_i, core_tx_b_i, core_tx_active_a_i,
    input wire logic logic_rx_chan_b_i, line_tx_chan_a_o, logic_tx_chan_b_o, core_rx_a_o,
    input wire logic core_rx_b_o, core_rst_o, bus_isolate_o, chan_select_addr_o,
    input wire logic charge_pump_off_o, osc_buffered_out_o,
    input wire dupc_pkg::dupc_bus_mode_t bus_mode_o
);
    import dupc_pkg::*;
    logic strobe;
    assign strobe = bus_mode_o == DUPC_BUS_STROBE;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    a_line_tx_idle: assert property (
        !$past(core_tx_active_a_i) || $past(core_rst_o) |-> !line_tx_chan_a_o) else $error("tx a");
    a_logic_tx_copy: assert property (
        !$past(core_rst_o) |-> logic_tx_chan_b_o == $past(core_tx_b_i)) else $error("tx b");
    a_reset_out_hold: assert property (
        $past(core_rst_o) |-> logic_tx_chan_b_o && core_rx_a_o && core_rx_b_o) else $error("hold");
    a_rx_b_source: assert property (
        !$past(core_rst_o) && $past(chan_b_rx_source_sel_i, 3)
        |-> core_rx_b_o == $past(logic_rx_chan_b_i, 3)) else $error("rx b");
    a_rst_polarity: assert property (
        (reset_pin_i ~^ strobe) [*3] |-> core_rst_o) else $error("rst on");
    a_rst_release: assert property (
        (reset_pin_i ^ strobe) [*8] |-> !core_rst_o) else $error("rst off");
    a_bus_mode: assert property (
        !$past(core_rst_o) |-> bus_mode_o == dupc_bus_mode_t'(bus_mode_strap_i)) else $error("mode");
    a_chan_sel: assert property (
        !$past(core_rst_o) && !strobe |-> chan_select_addr_o == $past(chip_sel_chan_b_i, 3))
        else $error("chan");
    a_bus_isolate: assert property (
        (bus_isolate_in_i && core_asleep_i && !core_rst_o) [*4] |-> bus_isolate_o) else $error("iso");
    a_pump_off: assert property (
        (charge_pump_autosleep_i && osc_stopped_i && core_asleep_i && !core_rst_o) [*4]
        |-> charge_pump_off_o) else $error("pump");
    a_osc_copy: assert property (osc_buffered_out_o == osc_in_i) else $error("osc");
    c_pin_reset: cover property ($rose(core_rst_o));
    c_rx_logic: cover property (chan_b_rx_source_sel_i && core_rx_b_o);
    c_pump_off: cover property (charge_pump_off_o);
endmodule

// file: test/dupc_far_model.sv
// Far-side model of the serial receive pins
`timescale 1ns/1ps
module dupc_far_model (
    // Clock, selector and bits to send
    input wire logic core_clk_i, sel_i, bit_a_i, bit_b_i,
    // Receive pins toward the block
    output logic line_rx_a_o, line_rx_b_o, logic_rx_b_o
);
    logic wobble = 1'h0;
    // An open pin must not look steady, so it changes every cycle
    always_ff @(posedge core_clk_i) wobble <= !wobble;
    assign line_rx_a_o = bit_a_i;
    assign line_rx_b_o = sel_i ? 1'h0 : bit_b_i;
    assign logic_rx_b_o = sel_i ? bit_b_i : wobble;
endmodule

// file: test/test_dupc_top.sv
// Self-checking bench for the pin, mode and reset control
`timescale 1ns/1ps
module test_dupc_top;
    import dupc_pkg::*;
    logic core_clk_i = 1'h0, arst_n_i = 1'h0, strap = 1'h1, rpin = 1'h0, iso = 1'h0, charge_pump_autosleep = 1'h0;
    logic sel = 1'h0, csb = 1'h0, osc = 1'h0, asleep = 1'h0, ostop = 1'h0, txa = 1'h1, logic_tx_chan_b = 1'h1;
    logic acta = 1'h0, bita = 1'h0, bitb = 1'h0, rxa, logic_rx_chan_b, lrxb, ltxa, ltx, crxa, crxb, crst, biso;
    logic csel, cpo, ltxb;
    dupc_bus_mode_t mode;
    int errors = 0, samples_checked = 0;
    dupc_far_model u_far (.core_clk_i, .sel_i(sel), .bit_a_i(bita), .bit_b_i(bitb),
        .line_rx_a_o(rxa), .line_rx_b_o(logic_rx_chan_b), .logic_rx_b_o(lrxb));
    dupc_top u_dut (.core_clk_i, .arst_n_i, .bus_mode_strap_i(strap), .reset_pin_i(rpin),
        .bus_isolate_in_i(iso), .charge_pump_autosleep_i(charge_pump_autosleep), .chan_b_rx_source_sel_i(sel),
        .chip_sel_chan_b_i(csb), .osc_in_i(osc), .core_asleep_i(asleep), .osc_stopped_i(ostop),
        .core_tx_a_i(txa), .core_tx_b_i(logic_tx_chan_b), .core_tx_active_a_i(acta), .core_tx_active_b_i(acta),
        .line_rx_chan_a_i(rxa), .line_rx_chan_b_i(logic_rx_chan_b), .logic_rx_chan_b_i(lrxb),
        .line_tx_chan_a_o(ltxa), .line_tx_chan_b_o(ltxb), .logic_tx_chan_b_o(ltx),
        .core_rx_a_o(crxa),
        .core_rx_b_o(crxb), .core_rst_o(crst), .bus_mode_o(mode), .bus_isolate_o(biso),
        .chan_select_addr_o(csel), .charge_pump_off_o(cpo), .osc_buffered_out_o());
    initial begin
        forever #50 core_clk_i = !core_clk_i;
    end
    always @(posedge core_clk_i) osc <= !osc;
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %b, seen %b", nm, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk_i);
        arst_n_i <= 1'h1;
        wt(8);
        chk("mode", mode, 1'h1);
        chk("rst", crst, 1'h0);
        chk("tx a", ltxa, 1'h0);
        @(posedge core_clk_i) {acta, txa, logic_tx_chan_b, sel, bitb} <= 5'h12;
        wt(5);
        chk("tx a", ltxa, 1'h1);
        chk("line tx b", ltxb, 1'h1);
        chk("tx b", ltx, 1'h0);
        chk("rx b", crxb, 1'h0);
        @(posedge core_clk_i) sel <= 1'h0;
        wt(5);
        chk("rx b", crxb, 1'h1);
        @(posedge core_clk_i) {acta, iso, asleep, charge_pump_autosleep, ostop} <= 5'h0f;
        wt(6);
        chk("tx a", ltxa, 1'h0);
        chk("line tx b", ltxb, 1'h0);
        chk("iso", biso, 1'h1);
        chk("pump", cpo, 1'h1);
        @(posedge core_clk_i) {ostop, iso} <= 2'h0;
        wt(6);
        chk("pump", cpo, 1'h0);
        chk("iso", biso, 1'h0);
        @(posedge core_clk_i) {rpin, acta} <= 2'h3;
        wt(4);
        chk("rst", crst, 1'h1);
        chk("tx a", ltxa, 1'h0);
        chk("line tx b", ltxb, 1'h0);
        chk("tx b", ltx, 1'h1);
        chk("rx b", crxb, 1'h1);
        @(posedge core_clk_i) rpin <= 1'h0;
        wt(8);
        chk("rst", crst, 1'h0);
        @(posedge core_clk_i) {arst_n_i, strap, rpin, csb} <= 4'h3;
        wt(2);
        chk("rst", crst, 1'h1);
        chk("rx a", crxa, 1'h1);
        chk("tx b", ltx, 1'h1);
        @(posedge core_clk_i) arst_n_i <= 1'h1;
        wt(1);
        chk("rst", crst, 1'h1);
        wt(7);
        chk("mode", mode, 1'h0);
        chk("rst", crst, 1'h0);
        chk("chan", csel, 1'h1);
        @(posedge core_clk_i) rpin <= 1'h0;
        wt(4);
        chk("rst", crst, 1'h1);
        end_sim;
    end
    initial begin
        #100000;
        errors++;
        end_sim;
    end
endmodule
bind dupc_top dupc_chk u_chk (.*);
